// ==== core/lsbc_register_bank.v ====
// control register bank with two-wire serial slave and window watchdog trigger
// Notes on behaviour
// - device only answers; the microcontroller starts every serial frame
// - serial port addresses 32 locations of 8 bits each
// - configuration bit 3 enables the LIN transceiver; resets to 0000_1111
// - shutdown bit 0 set requests temporary shutdown; resets to zero
// - trigger outside the open window asserts the reset output
// - every trigger restarts the window watchdog counter from its start value
// - trigger bit clears itself within one 128 kHz clock period
// - low side driver data is read/write but has no effect
// - command byte: read flag, two length bits, five address bits
// - length codes select 1, 2, 4 or 8 bytes; every frame leaves port mode after its last byte
// - address increments per byte after the first; data goes MSB first
// - sender drives on serial clock rise, receiver samples on following fall
`timescale 1ns/1ps
`default_nettype none
`include "lsbc_map.vh"
module lsbc_register_bank (
  // clock and resets (rst is the logic-supply power-on reset)
  input wire clk_sys,
  input wire rst,
  input wire rstVsup,
  // serial port pins
  input wire spModeActive,
  input wire enPin,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  output wire spExit,
  // watchdog clock pin
  input wire wdClkPin,
  // device controls
  output wire linEnable,
  output wire tempShutdown,
  output wire deviceControl,
  output wire wdResetReq
);
  localparam [3:0] ST_CMD = 4'h1;
  localparam [3:0] ST_WDATA = 4'h2;
  localparam [3:0] ST_RDATA = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;
  localparam [7:0] CTRL_RST = `LSBC_RST_DEVICE_CONTROL;

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [2:0] bitCnt_ff;
  reg [7:0] rxShift_ff;
  reg [7:0] txShift_ff;
  reg [4:0] addr_ff;
  reg [3:0] remain_ff;
  reg sdaOut_ff;
  reg spExit_ff;
  reg [7:0] cfg_ff;
  reg ctrl_ff;
  reg shut_ff;
  reg trig_ff;
  reg [7:0] lsd_ff;
  reg [`LSBC_WD_CNT_W-1:0] wdCnt_ff;
  reg wdReset_ff;

  wire enRise;
  wire enFall;
  wire sdaLevel;
  wire wdTick;
  wire [7:0] rxByte;
  wire byteEnd;
  wire wrStrobe;
  wire [4:0] nextAddr;
  wire wdWindowOpen;

  lsbc_pin_sync u_en_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn(enPin),
    .level(),
    .rise(enRise),
    .fall(enFall)
  );

  lsbc_pin_sync u_sda_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn(sdaIn),
    .level(sdaLevel),
    .rise(),
    .fall()
  );

  lsbc_pin_sync u_wd_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn(wdClkPin),
    .level(),
    .rise(wdTick),
    .fall()
  );

  // read mux; unmapped and write-only locations read zero
  function [7:0] regRead;
    input [4:0] a;
    begin
      case (a)
        `LSBC_OFS_DEVICE_CONFIGURATION: regRead = cfg_ff;
        `LSBC_OFS_DEVICE_CONTROL: regRead = {7'h00, ctrl_ff};
        `LSBC_OFS_TEMPORARY_SHUTDOWN: regRead = {7'h00, shut_ff};
        `LSBC_OFS_LOW_SIDE_DRIVER_DATA: regRead = lsd_ff;
        default: regRead = 8'h00;
      endcase
    end
  endfunction

  // byte count from the two length bits
  function [3:0] lenBytes;
    input [1:0] code;
    begin
      case (code)
        2'b00: lenBytes = 4'h1;
        2'b01: lenBytes = 4'h2;
        2'b10: lenBytes = 4'h4;
        default: lenBytes = 4'h8;
      endcase
    end
  endfunction

  assign rxByte = {rxShift_ff[6:0], sdaLevel};
  assign byteEnd = enFall & (bitCnt_ff == 3'h7);
  assign wrStrobe = byteEnd & state_ff[1];
  assign nextAddr = addr_ff + 5'h01;
  assign wdWindowOpen = (wdCnt_ff >= `LSBC_WD_OPEN) && (wdCnt_ff < `LSBC_WD_CLOSE);

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_CMD: begin
        if (byteEnd) begin
          nxt_state = rxByte[`LSBC_CMD_BIT_READ] ? ST_RDATA : ST_WDATA;
        end
      end
      ST_WDATA, ST_RDATA: begin
        if (byteEnd && remain_ff == 4'h1) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: nxt_state = ST_DONE;
      default: nxt_state = ST_CMD;
    endcase
  end

  // serial frame engine; frame state drops whenever port mode is left
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ST_CMD;
      bitCnt_ff <= 3'h0;
      rxShift_ff <= 8'h00;
      txShift_ff <= 8'h00;
      addr_ff <= 5'h00;
      remain_ff <= 4'h0;
      sdaOut_ff <= 1'b0;
      spExit_ff <= 1'b0;
    end else if (!spModeActive) begin
      state_ff <= ST_CMD;
      bitCnt_ff <= 3'h0;
      sdaOut_ff <= 1'b0;
      spExit_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      spExit_ff <= 1'b0;
      if (enFall && !state_ff[3]) begin
        rxShift_ff <= rxByte;
        bitCnt_ff <= bitCnt_ff + 3'h1;
      end
      if (enRise && state_ff[2]) begin
        sdaOut_ff <= txShift_ff[7];
        txShift_ff <= {txShift_ff[6:0], 1'b0};
      end
      if (byteEnd && state_ff[0]) begin
        addr_ff <= rxByte[4:0];
        remain_ff <= lenBytes(rxByte[6:5]);
        txShift_ff <= regRead(rxByte[4:0]);
      end
      if (byteEnd && (state_ff[1] || state_ff[2])) begin
        addr_ff <= nextAddr;
        remain_ff <= remain_ff - 4'h1;
        txShift_ff <= regRead(nextAddr);
        if (remain_ff == 4'h1) begin
          spExit_ff <= 1'b1;
        end
      end
    end
  end

  // logic-supply reset registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_ff <= `LSBC_RST_DEVICE_CONFIGURATION;
      shut_ff <= 1'b0;
      lsd_ff <= `LSBC_RST_LOW_SIDE_DRIVER_DATA;
      trig_ff <= 1'b0;
    end else begin
      if (wrStrobe && addr_ff == `LSBC_OFS_DEVICE_CONFIGURATION) begin
        cfg_ff <= {4'h0, rxByte[`LSBC_BIT_LIN_ENABLE], 3'h7};
      end
      if (wrStrobe && addr_ff == `LSBC_OFS_TEMPORARY_SHUTDOWN) begin
        shut_ff <= rxByte[`LSBC_BIT_SHUTDOWN];
      end
      if (wrStrobe && addr_ff == `LSBC_OFS_LOW_SIDE_DRIVER_DATA) begin
        lsd_ff <= rxByte;
      end
      // a new trigger write wins over the self-clear
      if (wrStrobe && addr_ff == `LSBC_OFS_WATCHDOG_TRIGGER &&
          rxByte[`LSBC_BIT_WATCHDOG_TRIGGER]) begin
        trig_ff <= 1'b1;
      end else if (wdTick) begin
        trig_ff <= 1'b0;
      end
    end
  end

  // battery-supply reset register
  always @(posedge clk_sys or posedge rstVsup) begin
    if (rstVsup) begin
      ctrl_ff <= CTRL_RST[0];
    end else if (wrStrobe && addr_ff == `LSBC_OFS_DEVICE_CONTROL) begin
      ctrl_ff <= rxByte[`LSBC_BIT_DEVICE_CONTROL];
    end
  end

  // window watchdog counter on 128 kHz ticks
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdCnt_ff <= {`LSBC_WD_CNT_W{1'b0}};
      wdReset_ff <= 1'b0;
    end else begin
      wdReset_ff <= 1'b0;
      if (wdTick && trig_ff) begin
        wdCnt_ff <= {`LSBC_WD_CNT_W{1'b0}};
        wdReset_ff <= ~wdWindowOpen;
      end else if (wdTick && wdCnt_ff != `LSBC_WD_CNT_MAX) begin
        wdCnt_ff <= wdCnt_ff + 1'b1;
      end
    end
  end

  assign sdaOut = sdaOut_ff;
  assign sdaOe = state_ff[2] & spModeActive;
  assign spExit = spExit_ff & (remain_ff == 4'h0) & ~state_ff[0];
  assign linEnable = cfg_ff[`LSBC_BIT_LIN_ENABLE];
  assign tempShutdown = shut_ff;
  assign deviceControl = ctrl_ff;
  assign wdResetReq = wdReset_ff;
endmodule // lsbc_register_bank
`default_nettype wire

// ==== core/lsbc_map.vh ====
// register map, field positions, reset values and timing counts of the control bank
`ifndef LSBC_MAP_VH
`define LSBC_MAP_VH

`define LSBC_ADDR_W 5
`define LSBC_DATA_W 8
`define LSBC_NUM_REGS 32

`define LSBC_OFS_DEVICE_CONFIGURATION 5'h03
`define LSBC_OFS_DEVICE_CONTROL 5'h04
`define LSBC_OFS_TEMPORARY_SHUTDOWN 5'h05
`define LSBC_OFS_WATCHDOG_TRIGGER 5'h06
`define LSBC_OFS_LOW_SIDE_DRIVER_DATA 5'h07

`define LSBC_RST_DEVICE_CONFIGURATION 8'h0F
`define LSBC_RST_DEVICE_CONTROL 8'h01
`define LSBC_RST_TEMPORARY_SHUTDOWN 8'h00
`define LSBC_RST_WATCHDOG_TRIGGER 8'h00
`define LSBC_RST_LOW_SIDE_DRIVER_DATA 8'h00

`define LSBC_BIT_LIN_ENABLE 3
`define LSBC_BIT_DEVICE_CONTROL 0
`define LSBC_BIT_SHUTDOWN 0
`define LSBC_BIT_WATCHDOG_TRIGGER 0

`define LSBC_CMD_BIT_READ 7
`define LSBC_CMD_BIT_LEN_HIGH 6
`define LSBC_CMD_BIT_LEN_LOW 5

`define LSBC_WD_CNT_W 12
`define LSBC_WD_OPEN 12'h010
`define LSBC_WD_CLOSE 12'h080
`define LSBC_WD_CNT_MAX 12'hFFF

`endif

// ==== core/lsbc_pin_sync.v ====
// three-stage synchroniser with agreement filter and edge detection for one pin
`timescale 1ns/1ps
`default_nettype none
module lsbc_pin_sync (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // pin side
  input wire pinIn,
  // filtered level and edges
  output wire level,
  output wire rise,
  output wire fall
);
  reg stage1_ff;
  reg stage2_ff;
  reg stage3_ff;
  reg level_ff;
  reg rise_ff;
  reg fall_ff;
  wire agree;
  wire nxt_level;

  assign agree = (stage2_ff == stage3_ff);
  assign nxt_level = agree ? stage3_ff : level_ff;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
      stage3_ff <= 1'b0;
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff <= nxt_level;
      rise_ff <= nxt_level & ~level_ff;
      fall_ff <= ~nxt_level & level_ff;
    end
  end

  assign level = level_ff;
  assign rise = rise_ff;
  assign fall = fall_ff;
endmodule // lsbc_pin_sync
`default_nettype wire

// ==== dv/lsbc_checker_sva.sv ====
// port assertions for the control register bank
`timescale 1ns/1ps
`default_nettype none
module lsbc_checker (
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rstVsup,
  // serial pins
  input wire logic spModeActive,
  input wire logic enPin,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic spExit,
  // watchdog and controls
  input wire logic wdClkPin,
  input wire logic linEnable,
  input wire logic tempShutdown,
  input wire logic deviceControl,
  input wire logic wdResetReq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence idleTwo;
    !spModeActive [*2];
  endsequence
  sequence enQuiet;
    (!enPin && spModeActive) [*8];
  endsequence
  a_no_self_start: assert property (idleTwo |-> !sdaOe && !spExit)
    else $error("port active outside a frame");
  a_exit_single: assert property (spExit |=> !spExit)
    else $error("exit pulse too long");
  a_wd_pulse: assert property (wdResetReq |=> !wdResetReq)
    else $error("reset request too long");
  a_lin_quiet: assert property (!$stable(linEnable) |-> spModeActive)
    else $error("transceiver enable moved outside a frame");
  a_shut_quiet: assert property (!$stable(tempShutdown) |-> spModeActive)
    else $error("shutdown moved outside a frame");
  a_sda_hold: assert property (enQuiet |-> $stable(sdaOut))
    else $error("read data moved while clock low");
  a_oe_frame: assert property (sdaOe |-> spModeActive || $past(spModeActive))
    else $error("data driven outside a frame");
  a_reset_vals: assert property (disable iff (1'b0)
    rst |-> linEnable && !tempShutdown && !sdaOe && !wdResetReq)
    else $error("wrong value during reset");
endmodule // lsbc_checker
bind lsbc_register_bank lsbc_checker u_lsbc_checker (.clk_sys(clk_sys), .rst(rst),
  .rstVsup(rstVsup), .spModeActive(spModeActive), .enPin(enPin), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .spExit(spExit), .wdClkPin(wdClkPin),
  .linEnable(linEnable), .tempShutdown(tempShutdown), .deviceControl(deviceControl),
  .wdResetReq(wdResetReq));
`default_nettype wire

// ==== dv/lsbc_mcu_model.sv ====
// microcontroller side of the two-wire port: clock, data and mode pins
`timescale 1ns/1ps
`default_nettype none
module lsbc_mcu_model (
  // clock for edge alignment
  input wire logic clk_sys,
  // device side
  input wire logic sdaOut,
  input wire logic sdaOe,
  // pins driven here
  output logic enPin,
  output logic sdaIn,
  output logic spModeActive
);
  logic drv;
  logic bitV;
  // released data line sits at its pull-up level
  assign sdaIn = sdaOe ? sdaOut : (drv ? bitV : 1'b1);
  initial begin
    enPin = 1'b0;
    drv = 1'b0;
    bitV = 1'b0;
    spModeActive = 1'b0;
  end
  task automatic byteIo(input logic [7:0] tx, input logic out, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      enPin = 1'b1;
      drv = out;
      bitV = tx[i];
      #200;
      enPin = 1'b0;
      #200;
      rx[i] = sdaOut;
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [63:0] wd, output logic [63:0] rd);
    logic [7:0] b;
    int n;
    n = 1 << cmd[6:5];
    rd = '0;
    @(negedge clk_sys);
    spModeActive = 1'b1;
    #200;
    byteIo(cmd, 1'b1, b);
    for (int k = 0; k < n; k++) begin
      byteIo(wd[63-8*k -: 8], !cmd[7], b);
      rd[63-8*k -: 8] = b;
    end
    drv = 1'b0;
    #400;
    spModeActive = 1'b0;
    #400;
  endtask
endmodule // lsbc_mcu_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, rst, rstVsup, wdClkPin, wdSeen;
  wire enPin, sdaIn, sdaOut, sdaOe, spExit, spModeActive;
  wire linEnable, tempShutdown, deviceControl, wdResetReq;
  logic [63:0] rd;
  int errors, check_count, exitCnt;
  lsbc_register_bank u_lsbc_register_bank (.clk_sys(clk_sys), .rst(rst), .rstVsup(rstVsup),
    .spModeActive(spModeActive), .enPin(enPin), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .spExit(spExit), .wdClkPin(wdClkPin), .linEnable(linEnable),
    .tempShutdown(tempShutdown), .deviceControl(deviceControl), .wdResetReq(wdResetReq));
  lsbc_mcu_model u_lsbc_mcu_model (.clk_sys(clk_sys), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .enPin(enPin), .sdaIn(sdaIn), .spModeActive(spModeActive));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    wdClkPin = 1'b0;
    forever begin
      repeat (78) @(negedge clk_sys);
      wdClkPin = ~wdClkPin;
    end
  end
  always @(posedge clk_sys) if (wdResetReq === 1'b1) wdSeen <= 1'b1;
  // port exit pulses, one expected per frame
  always @(posedge clk_sys) if (spExit === 1'b1) exitCnt <= exitCnt + 1;
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xf(input logic [7:0] cmd, input logic [63:0] wd);
    int e;
    e = exitCnt;
    u_lsbc_mcu_model.frame(cmd, wd, rd);
    chk(exitCnt - e, 64'h1);
  endtask
  task trig(input logic exp);
    wdSeen = 1'b0;
    xf(8'h06, {8'h01, 56'h0});
    repeat (320) @(negedge clk_sys);
    chk(wdSeen, exp);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    rstVsup = 1'b1;
    wdSeen = 1'b0;
    exitCnt = 0;
    errors = 0;
    check_count = 0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    rstVsup = 1'b0;
    chk({linEnable, tempShutdown, deviceControl}, 3'h5);
    trig(1'b1);
    xf(8'h86, 64'h0);
    chk(rd[63:56], 8'h00);
    repeat (32 * 156) @(negedge clk_sys);
    trig(1'b0);
    trig(1'b1);
    xf(8'hE0, 64'h0);
    chk(rd, 64'h0000000F01000000);
    xf(8'h03, 64'h0);
    chk(linEnable, 1'b0);
    xf(8'h83, 64'h0);
    chk(rd[63:56], 8'h07);
    xf(8'h03, {8'hF8, 56'h0});
    chk(linEnable, 1'b1);
    xf(8'h24, {16'hFEFF, 48'h0});
    chk({deviceControl, tempShutdown}, 2'h1);
    xf(8'hC4, 64'h0);
    chk(rd[63:32], 32'h00010000);
    xf(8'h47, {32'hA5FFFFFF, 32'h0});
    xf(8'hA7, 64'h0);
    chk(rd[63:48], 16'hA500);
    // a trigger after the window has closed must also request reset
    repeat (140 * 156) @(negedge clk_sys);
    trig(1'b1);
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
